// ===== hw/touch_converter_params.svh
/*
  Register offsets, pages, field positions, reset values and mode codes
  for the touch converter scan/compare/pin-watch block.
  Assumes inclusion by bare name from the scan design file; the package does not include it.
*/
`ifndef TOUCH_CONVERTER_PARAMS_SVH
`define TOUCH_CONVERTER_PARAMS_SVH

`define PAGE_MAIN 8'h00
`define PAGE_AUX 8'h0F

`define OFS_SCAN_FIRST 8'h92
`define OFS_SCAN_LAST 8'h93
`define OFS_THR_LOW 8'h96
`define OFS_THR_HIGH 8'h97
`define OFS_PIN_WATCH 8'h9F
`define OFS_RESULT_LOW 8'hA9

`define RST_BYTE 8'h00
`define RST_CHAN 6'h00

`define BIT_WATCH_UART 7
`define BIT_WATCH_SPI 6
`define BIT_WATCH_SMBUS 5
`define BIT_WATCH_CNT_ARRAY 4
`define BIT_WATCH_PORT_WR 3
`define BIT_WATCH_CMP 2

`define TRIG_SINGLE 3'h0
`define TRIG_CONT 3'h6
`define TRIG_AUTOSCAN 3'h7

`define RETRY_LIMIT_TWICE 3'h2
`define RETRY_LIMIT_FOUR 3'h4

`endif

// ===== hw/touch_converter_pkg.sv
/*
  Types shared by the touch converter block.
  Needs nothing on the include path; the params header is not used here.
*/
package touch_converter_pkg;
  typedef logic [5:0] channel_t;
  typedef enum logic [1:0] {
    RETRY_ALWAYS = 2'h0,
    RETRY_TWICE = 2'h1,
    RETRY_FOUR = 2'h2,
    RETRY_RSVD = 2'h3
  } retry_policy_t;
endpackage : touch_converter_pkg

// ===== hw/touch_converter_scan.sv
/*
  Touch converter register slice: result low byte, auto-scan channel range,
  comparator threshold and the pin-watch retry unit.
  Assumes an 8-bit paged SFR port from the core, single-cycle strobes, and an
  analog converter that pulses conv_done_i / bit_cycle_i on ref_clk_i.
*/
// Notes on behaviour
// - result low byte is read-only, low eight bits of last result, resets zero
// - scan first field bits 5:0 picks first channel during auto-scan
// - writing scan first during auto-scan also loads channel select
// - scan last field bits 5:0 picks last channel during auto-scan
// - first and last fields accept every channel-select code
// - bits 7:6 of channel registers read zero, writes ignored
// - threshold high byte is read-write, upper eight threshold bits
// - threshold low byte is read-write, lower eight threshold bits
// - watch bit 7 monitors uart transmit pin changes during conversion
// - watch bit 6 monitors spi output pin changes during conversion
// - watch bit 5 monitors smbus pin changes during conversion
// - watch bit 4 monitors counter array output changes during conversion
// - watch bit 3 treats any port latch write during conversion as an event
// - watch bit 2 monitors synchronous analog comparator output changes
// - retry policy bits 1:0 choose reaction to monitored changes
// - policy zero retries every affected bit cycle, unlimited
// - policy one retries at most twice over consecutive bit cycles
// - policy two retries at most four times; policy three reserved
// - sticky pin event flag set on any retry, software clears
// - enabled comparator sets flag when result exceeds threshold
// - trigger mode 111 enables auto-scan, back-to-back after busy write
`timescale 1ns/1ps
`default_nettype none
`include "touch_converter_params.svh"

module touch_converter_scan
  import touch_converter_pkg::*;
#(
  parameter int SPI_W = 3,
  parameter int SMB_W = 2,
  parameter int CNT_W = 3
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [2:0] conversion_trigger_mode_i,
  input wire logic busy_wr_one_i,
  input wire logic cmp_enable_i,
  input wire logic cmp_flag_clr_i,
  input wire logic pin_event_clr_i,
  input wire logic channel_select_wr_i,
  input wire logic [5:0] channel_select_wdata_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_result_i,
  input wire logic bit_cycle_i,
  input wire logic uart_tx_i,
  input wire logic [SPI_W-1:0] spi_out_i,
  input wire logic [SMB_W-1:0] smbus_i,
  input wire logic [CNT_W-1:0] counter_array_out_i,
  input wire logic port_latch_wr_i,
  input wire logic comparator_sync_i,
  output logic conversion_in_progress_o,
  output logic [5:0] channel_select_o,
  output logic threshold_exceeded_flag_o,
  output logic pin_event_flag_o,
  output logic retry_o
);

  localparam int MON_W = 2 + SPI_W + SMB_W + CNT_W;

  logic [7:0] result_low_r;
  channel_t scan_first_r, scan_last_r, channel_r;
  logic [7:0] thr_low_r, thr_high_r, pin_watch_r, rdata_r;
  logic busy_r, cmp_flag_r, pin_flag_r, retry_r, pending_r;
  logic [2:0] retry_cnt_r;
  logic [MON_W-1:0] mon_prev_r;

  // address decode
  wire page_main = (sfr_page_i == `PAGE_MAIN);
  wire page_aux = (sfr_page_i == `PAGE_AUX);
  wire sel_first = page_aux && (sfr_addr_i == `OFS_SCAN_FIRST);
  wire sel_last = page_aux && (sfr_addr_i == `OFS_SCAN_LAST);
  wire sel_watch = page_aux && (sfr_addr_i == `OFS_PIN_WATCH);
  wire sel_thl = page_main && (sfr_addr_i == `OFS_THR_LOW);
  wire sel_thh = page_main && (sfr_addr_i == `OFS_THR_HIGH);
  wire sel_res = page_main && (sfr_addr_i == `OFS_RESULT_LOW);
  wire wr_first = sfr_wr_i && sel_first;
  wire wr_last = sfr_wr_i && sel_last;
  wire wr_watch = sfr_wr_i && sel_watch;
  wire wr_thl = sfr_wr_i && sel_thl;
  wire wr_thh = sfr_wr_i && sel_thh;

  wire [15:0] threshold = {thr_high_r, thr_low_r};
  wire autoscan = (conversion_trigger_mode_i == `TRIG_AUTOSCAN);
  wire continuous = autoscan || (conversion_trigger_mode_i == `TRIG_CONT);
  wire start_ok = continuous || (conversion_trigger_mode_i == `TRIG_SINGLE);
  retry_policy_t policy;
  assign policy = retry_policy_t'(pin_watch_r[1:0]);

  // reserved bits come back as zero because only six bits are stored
  wire [7:0] rd_mux =
    sel_first ? {2'h0, scan_first_r} :
    sel_last ? {2'h0, scan_last_r} :
    sel_watch ? pin_watch_r :
    sel_thl ? thr_low_r :
    sel_thh ? thr_high_r :
    sel_res ? result_low_r :
    8'h00;

  // pin monitor: per-source change detect, gated by enables
  wire [MON_W-1:0] mon_now = {uart_tx_i, spi_out_i, smbus_i, counter_array_out_i,
                              comparator_sync_i};
  wire [MON_W-1:0] mon_chg = mon_now ^ mon_prev_r;
  wire [MON_W-1:0] mon_en = {pin_watch_r[`BIT_WATCH_UART],
                             {SPI_W{pin_watch_r[`BIT_WATCH_SPI]}},
                             {SMB_W{pin_watch_r[`BIT_WATCH_SMBUS]}},
                             {CNT_W{pin_watch_r[`BIT_WATCH_CNT_ARRAY]}},
                             pin_watch_r[`BIT_WATCH_CMP]};
  wire port_evt = pin_watch_r[`BIT_WATCH_PORT_WR] && port_latch_wr_i;
  wire mon_event = busy_r && ((|(mon_chg & mon_en)) || port_evt);
  wire pend_now = pending_r || mon_event;

  wire [2:0] retry_limit =
    (policy == RETRY_TWICE) ? `RETRY_LIMIT_TWICE :
    (policy == RETRY_FOUR) ? `RETRY_LIMIT_FOUR :
    3'h0;
  // reserved policy issues no retries rather than guessing a limit
  wire retry_allowed = (policy == RETRY_ALWAYS) || (retry_cnt_r < retry_limit);
  wire retry_fire = busy_r && bit_cycle_i && pend_now && retry_allowed;

  // busy and auto-scan stepping
  wire start = busy_wr_one_i && start_ok;
  wire busy_nxt = start ? 1'b1 :
                  (conv_done_i && !continuous) ? 1'b0 : busy_r;
  wire step = conv_done_i && busy_r && autoscan;
  wire [5:0] chan_inc = channel_r + 6'h01;
  wire [5:0] channel_nxt =
    channel_select_wr_i ? channel_select_wdata_i :
    (wr_first && autoscan) ? sfr_wdata_i[5:0] :
    !step ? channel_r :
    (channel_r == scan_last_r) ? scan_first_r : chan_inc;
  wire cmp_hit = conv_done_i && cmp_enable_i && (conv_result_i > threshold);
  // unlimited policy leaves the count alone, so a later switch to a limit never starts above it
  wire [2:0] cnt_nxt = !busy_r ? 3'h0 :
                       (retry_fire && policy != RETRY_ALWAYS) ? retry_cnt_r + 3'h1 :
                       (bit_cycle_i && !pend_now) ? 3'h0 : retry_cnt_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_first_r <= `RST_CHAN;
      scan_last_r <= `RST_CHAN;
      thr_low_r <= `RST_BYTE;
      thr_high_r <= `RST_BYTE;
      pin_watch_r <= `RST_BYTE;
      rdata_r <= `RST_BYTE;
    end else begin
      if (wr_first) scan_first_r <= sfr_wdata_i[5:0];
      if (wr_last) scan_last_r <= sfr_wdata_i[5:0];
      if (wr_thl) thr_low_r <= sfr_wdata_i;
      if (wr_thh) thr_high_r <= sfr_wdata_i;
      if (wr_watch) pin_watch_r <= sfr_wdata_i;
      if (sfr_rd_i) rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_low_r <= `RST_BYTE;
      channel_r <= `RST_CHAN;
      busy_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else begin
      if (conv_done_i) result_low_r <= conv_result_i[7:0];
      channel_r <= channel_nxt;
      busy_r <= busy_nxt;
      // set beats a clear landing in the same cycle
      cmp_flag_r <= cmp_hit || (cmp_flag_r && !cmp_flag_clr_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mon_prev_r <= '0;
      pending_r <= 1'b0;
      retry_cnt_r <= 3'h0;
      retry_r <= 1'b0;
      pin_flag_r <= 1'b0;
    end else begin
      mon_prev_r <= mon_now;
      pending_r <= busy_r && !bit_cycle_i && pend_now;
      retry_cnt_r <= cnt_nxt;
      retry_r <= retry_fire;
      pin_flag_r <= retry_fire || (pin_flag_r && !pin_event_clr_i);
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign conversion_in_progress_o = busy_r;
  assign channel_select_o = channel_r;
  assign threshold_exceeded_flag_o = cmp_flag_r;
  assign pin_event_flag_o = pin_flag_r;
  assign retry_o = retry_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_scan_write;
    wr_first && autoscan && !channel_select_wr_i;
  endsequence

  sequence s_wrap_step;
    step && (channel_r == scan_last_r) && !channel_select_wr_i && !wr_first;
  endsequence

  sequence s_inc_step;
    step && (channel_r != scan_last_r) && !channel_select_wr_i && !wr_first;
  endsequence

  AST_RESULT_LOAD: assert property (
    conv_done_i |=> result_low_r == $past(conv_result_i[7:0]))
    else $error("result low byte not loaded");

  AST_SCAN_WR_CHAN: assert property (
    s_scan_write |=> channel_select_o == $past(sfr_wdata_i[5:0]))
    else $error("scan first write did not reach channel select");

  AST_RSVD_ZERO: assert property (
    sfr_rd_i && (sel_first || sel_last) |=> sfr_rdata_o[7:6] == 2'h0)
    else $error("reserved channel bits read nonzero");

  AST_THR_HIGH: assert property (
    wr_thh |=> threshold[15:8] == $past(sfr_wdata_i))
    else $error("threshold high byte not written");

  AST_CMP_SET: assert property (
    cmp_hit |=> threshold_exceeded_flag_o)
    else $error("comparator flag missed");

  AST_CMP_QUIET: assert property (
    !cmp_enable_i && !threshold_exceeded_flag_o |=> !threshold_exceeded_flag_o)
    else $error("comparator flag set while disabled");

  AST_PIN_FLAG: assert property (
    retry_o |-> pin_event_flag_o)
    else $error("retry without pin event flag");

  AST_RETRY_ALWAYS: assert property (
    busy_r && bit_cycle_i && pend_now && policy == RETRY_ALWAYS |=> retry_o)
    else $error("unlimited policy did not retry");

  AST_RETRY_TWICE: assert property (
    policy == RETRY_TWICE && retry_cnt_r == 3'h2 && !wr_watch |=> !retry_o)
    else $error("policy one retried more than twice");

  AST_RETRY_FOUR: assert property (
    policy == RETRY_FOUR |-> retry_cnt_r <= 3'h4)
    else $error("policy two count beyond four");

  AST_PORT_EVT: assert property (
    busy_r && port_evt && !bit_cycle_i |=> pending_r)
    else $error("port latch write not seen");

  AST_SCAN_WRAP: assert property (
    s_wrap_step |=> channel_select_o == $past(scan_first_r))
    else $error("auto-scan did not wrap");

  AST_BUSY_START: assert property (
    start |=> conversion_in_progress_o)
    else $error("busy not set by start");

  AST_RESULT_HOLD: assert property (
    !conv_done_i |=> $stable(result_low_r))
    else $error("result low byte changed without a conversion");

  AST_THR_LOW: assert property (
    wr_thl |=> threshold[7:0] == $past(sfr_wdata_i))
    else $error("threshold low byte not written");

  AST_SCAN_STEP: assert property (
    s_inc_step |=> channel_select_o == $past(channel_r) + 6'h01)
    else $error("auto-scan did not step by one");

  AST_CMP_HOLD: assert property (
    threshold_exceeded_flag_o && !cmp_flag_clr_i |=> threshold_exceeded_flag_o)
    else $error("comparator flag lost without clear");

  AST_PIN_HOLD: assert property (
    pin_event_flag_o && !pin_event_clr_i |=> pin_event_flag_o)
    else $error("pin event flag lost without clear");

  AST_RETRY_RSVD: assert property (
    policy == RETRY_RSVD |=> !retry_o)
    else $error("reserved policy retried");

  AST_RETRY_IDLE: assert property (
    !busy_r |=> !retry_o)
    else $error("retry outside a conversion");

  AST_START_REFUSED: assert property (
    busy_wr_one_i && !start_ok && !busy_r |=> !conversion_in_progress_o)
    else $error("start accepted in a refused trigger mode");

endmodule : touch_converter_scan
`default_nettype wire

// ===== dv/touch_pad_model.sv
/*
  stand-in for the analog converter: bit-cycle and done pulses while run_i.
  assumes run_i follows the block's busy output and value_i is set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_pad_model (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic [15:0] value_i,
  output logic bit_cycle_o,
  output logic conv_done_o,
  output logic [15:0] conv_result_o
);
  logic [2:0] cnt_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_r <= 3'h0;
    else if (run_i) cnt_r <= cnt_r + 3'h1;
  end
  assign bit_cycle_o = run_i && (cnt_r[1:0] == 2'h3);
  assign conv_done_o = run_i && (cnt_r == 3'h7);
  // result lines carry junk outside the done pulse, so a stale capture shows
  assign conv_result_o = conv_done_o ? value_i : ~value_i;
endmodule : touch_pad_model
`default_nettype wire

// ===== dv/tb_top.sv
/*
  self-checking bench for the touch converter register slice.
  assumes the converter stand-in model and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 1'h0, arst_n_i = 1'h0, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
  logic busy_wr_one_i = 1'h0, cmp_enable_i = 1'h0, cmp_flag_clr_i = 1'h0;
  logic pin_event_clr_i = 1'h0, channel_select_wr_i = 1'h0, uart_tx_i = 1'h0;
  logic port_latch_wr_i = 1'h0, comparator_sync_i = 1'h0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_page_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [2:0] conversion_trigger_mode_i = 3'h0, spi_out_i = 3'h0, counter_array_out_i = 3'h0;
  logic [1:0] smbus_i = 2'h0;
  logic [5:0] channel_select_wdata_i = 6'h00, channel_select_o;
  logic conv_done_i, bit_cycle_i, conversion_in_progress_o;
  logic threshold_exceeded_flag_o, pin_event_flag_o, retry_o;
  logic [15:0] conv_result_i, value = 16'h0000;
  int err_count = 0, samples_checked = 0, retries = 0;

  always #50 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) if (retry_o === 1'h1) retries++;

  touch_converter_scan uut (.ref_clk_i, .arst_n_i, .sfr_addr_i, .sfr_page_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .conversion_trigger_mode_i, .busy_wr_one_i,
    .cmp_enable_i, .cmp_flag_clr_i, .pin_event_clr_i, .channel_select_wr_i,
    .channel_select_wdata_i, .conv_done_i, .conv_result_i, .bit_cycle_i, .uart_tx_i,
    .spi_out_i, .smbus_i, .counter_array_out_i, .port_latch_wr_i, .comparator_sync_i,
    .conversion_in_progress_o, .channel_select_o, .threshold_exceeded_flag_o,
    .pin_event_flag_o, .retry_o);
  touch_pad_model pad (.ref_clk_i, .arst_n_i, .run_i(conversion_in_progress_o),
    .value_i(value), .bit_cycle_o(bit_cycle_i), .conv_done_o(conv_done_i),
    .conv_result_o(conv_result_i));

  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task do_reset;
    arst_n_i = 1'h0;
    conversion_trigger_mode_i = 3'h0;
    tick;
    tick;
    arst_n_i = 1'h1;
  endtask : do_reset
  // each access ends with an idle edge so strobes never toggle twice in one step
  task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    sfr_page_i = p;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'h1;
    tick;
    sfr_wr_i = 1'h0;
    tick;
  endtask : wr
  task rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
    sfr_page_i = p;
    sfr_addr_i = a;
    sfr_rd_i = 1'h1;
    tick;
    sfr_rd_i = 1'h0;
    tick;
    d = sfr_rdata_o;
  endtask : rd
  task pulse_busy;
    busy_wr_one_i = 1'h1;
    tick;
    busy_wr_one_i = 1'h0;
    tick;
  endtask : pulse_busy
  task wait_done;
    int i;
    for (i = 0; i < 50 && conv_done_i !== 1'h1; i++) tick;
    if (i == 50) begin
      err_count++;
      wrap_up;
    end
    tick;
  endtask : wait_done

  task automatic t_regs;
    // page, offset, readback after writing all ones
    logic [23:0] tab [8] = '{24'h0F923F, 24'h0F933F, 24'h0096FF, 24'h0097FF,
                              24'h0F9FFF, 24'h00A900, 24'h0F9400, 24'h009200};
    logic [7:0] d;
    do_reset;
    foreach (tab[k]) begin
      rd(tab[k][23:16], tab[k][15:8], d);
      check("reset value", d, 16'h0000);
      wr(tab[k][23:16], tab[k][15:8], 8'hFF);
      rd(tab[k][23:16], tab[k][15:8], d);
      check("readback", d, {8'h00, tab[k][7:0]});
    end
    $display("register test done");
  endtask : t_regs

  task t_scan;
    logic [7:0] d;
    do_reset;
    value = 16'h1235;
    cmp_enable_i = 1'h1;
    conversion_trigger_mode_i = 3'h7;
    channel_select_wdata_i = 6'h2A;
    channel_select_wr_i = 1'h1;
    tick;
    channel_select_wr_i = 1'h0;
    check("direct select", channel_select_o, 16'h002A);
    wr(8'h00, 8'h96, 8'h34);
    wr(8'h00, 8'h97, 8'h12);
    wr(8'h0F, 8'h92, 8'h05);
    check("first loads select", channel_select_o, 16'h0005);
    wr(8'h0F, 8'h93, 8'h06);
    pulse_busy;
    check("busy", conversion_in_progress_o, 16'h0001);
    wait_done;
    check("step", channel_select_o, 16'h0006);
    wait_done;
    check("wrap", channel_select_o, 16'h0005);
    check("above threshold", threshold_exceeded_flag_o, 16'h0001);
    value = 16'h1234;
    cmp_flag_clr_i = 1'h1;
    tick;
    cmp_flag_clr_i = 1'h0;
    wait_done;
    check("equal threshold", threshold_exceeded_flag_o, 16'h0000);
    rd(8'h00, 8'hA9, d);
    check("result low", d, 16'h0034);
    $display("scan test done");
  endtask : t_scan

  task t_modes;
    do_reset;
    value = 16'h1234;
    cmp_enable_i = 1'h0;
    conversion_trigger_mode_i = 3'h1;
    pulse_busy;
    check("start refused", conversion_in_progress_o, 16'h0000);
    conversion_trigger_mode_i = 3'h0;
    wr(8'h0F, 8'h92, 8'h07);
    check("first without scan", channel_select_o, 16'h0000);
    pulse_busy;
    check("single busy", conversion_in_progress_o, 16'h0001);
    wait_done;
    check("single ends", conversion_in_progress_o, 16'h0000);
    check("no step", channel_select_o, 16'h0000);
    check("compare disabled", threshold_exceeded_flag_o, 16'h0000);
    $display("mode test done");
  endtask : t_modes

  task watch_run(input logic [7:0] pm, input logic [5:0] src, output int n);
    int i;
    do_reset;
    conversion_trigger_mode_i = 3'h6;
    wr(8'h0F, 8'h9F, pm);
    pulse_busy;
    tick;
    retries = 0;
    // an even count of toggles leaves every toggled source back at zero; the port latch strobe is cleared after the loop
    for (i = 0; i < 40; i++) begin
      uart_tx_i ^= src[5];
      spi_out_i ^= {3{src[4]}};
      smbus_i ^= {2{src[3]}};
      counter_array_out_i ^= {3{src[2]}};
      port_latch_wr_i = src[1];
      comparator_sync_i ^= src[0];
      tick;
    end
    port_latch_wr_i = 1'h0;
    repeat (6) tick;
    n = retries;
  endtask : watch_run

  task automatic t_watch;
    int n;
    int lim [4] = '{5, 2, 4, 0};
    for (int k = 0; k < 4; k++) begin
      watch_run({6'h20, k[1:0]}, 6'h20, n);
      check("retry count", 16'(n > 5 ? 5 : n), 16'(lim[k]));
      check("event flag", pin_event_flag_o, 16'(k != 3));
      pin_event_clr_i = 1'h1;
      tick;
      pin_event_clr_i = 1'h0;
      tick;
      check("event flag clear", pin_event_flag_o, 16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      watch_run(8'h04 << k, 6'h01 << k, n);
      check("watched source", 16'(n > 0), 16'h0001);
      watch_run(~(8'h04 << k) & 8'hFC, 6'h01 << k, n);
      check("unwatched source", 16'(n), 16'h0000);
    end
    $display("pin watch test done");
  endtask : t_watch

  initial begin
    t_regs;
    t_scan;
    t_modes;
    t_watch;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
